// ==== hdl/spn_regs.svh ====
// Opcodes, timing figures and host register map of the mode controller.
`ifndef SPN_REGS_SVH
`define SPN_REGS_SVH
`define SPN_OP_SLEEP_ENTER 8'h10
`define SPN_OP_SLEEP_EXIT  8'h11
`define SPN_OP_PARTIAL_ON  8'h12
`define SPN_OP_NORMAL_ON   8'h13
`define SPN_CLK_KHZ        25000
`define SPN_GAP_MS         5
`define SPN_LONG_MS        120
`define SPN_GAP_W          17
`define SPN_LONG_W         22
`define SPN_LOAD_CYCLES    17'h00010
`define SPN_SETUP_CYCLES   3'h3
`define SPN_LOW_CYCLES     3'h4
`define SPN_HOLD_CYCLES    3'h4
`define SPN_PIN_RST        10'h300
`define SPN_AXI_AW         4
`define SPN_ADDR_CMD       4'h0
`define SPN_ADDR_STATUS    4'h4
`define SPN_RESP_OKAY      2'h0
`define SPN_RESP_SLVERR    2'h2
`define SPN_ST_BUSY        0
`define SPN_ST_SLEEP       1
`define SPN_ST_PARTIAL     2
`define SPN_ST_LONG        3
`define SPN_DIAG_LOAD      7
`define SPN_DIAG_FUNC      6
`endif

// ==== hdl/spn_pkg.sv ====
// Shared state types and opcode helper of the mode controller.
`include "spn_regs.svh"
package spn_pkg;
    typedef enum logic [1:0] {
        ST_SLEEP = 2'b00,
        ST_LOAD  = 2'b01,
        ST_DIAG  = 2'b10,
        ST_AWAKE = 2'b11
    } spn_dev_state_t;

    typedef enum logic [1:0] {
        H_IDLE  = 2'b00,
        H_SETUP = 2'b01,
        H_LOW   = 2'b10,
        H_HOLD  = 2'b11
    } spn_host_state_t;

    function automatic logic spn_is_sleep_op(input logic [7:0] op);
        return (op == `SPN_OP_SLEEP_ENTER) || (op == `SPN_OP_SLEEP_EXIT);
    endfunction
endpackage

// ==== hdl/spn_link_if.sv ====
// Parallel command bus between the host controller and the display device.
`timescale 1ns/10ps
interface spn_link_if;
    logic        write_strobe_n;
    logic        read_strobe_n;
    logic        data_command_select;
    logic [15:0] data;

    modport dev (
        input write_strobe_n,
        input read_strobe_n,
        input data_command_select,
        input data
    );
    modport host (
        output write_strobe_n,
        output read_strobe_n,
        output data_command_select,
        output data
    );
endinterface

// ==== hdl/spn_dev.sv ====
// Device end: sleep, partial and normal mode command logic.
// How it works
// - Code 10h stops converter, oscillator, scanning.
// - Sleep keeps interface and frame memory alive.
// - No dimming on the way into sleep.
// - Sleep entry while asleep does nothing.
// - Only code 11h wakes the device.
// - Host waits 5 ms after 10h/11h.
// - Host waits 120 ms from wake to sleep.
// - Host waits 120 ms from sleep to wake.
// - Code 11h restarts converter, oscillator, scanning.
// - Defaults load within 5 ms of wake.
// - Self-diagnosis runs within 5 ms of wake.
// - Only code 10h sends the device asleep.
// - Reset leaves sleep with normal mode selected.
// - Code 12h turns partial mode on.
// - Host ends partial mode with code 13h.
// - Partial on while partial does nothing.
// - Code 13h clears partial and scroll modes; a same-cycle scroll start keeps scroll.
// - Normal on while normal does nothing.
`timescale 1ns/10ps
`include "spn_regs.svh"
module spn_dev #(
    parameter int unsigned WAKE_CYCLES = `SPN_GAP_MS * `SPN_CLK_KHZ
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    spn_link_if.dev               link,
    input  wire logic             scroll_start,
    input  wire logic             panel_ok,
    output spn_pkg::spn_dev_state_t dev_state,
    output logic                  dcdc_en,
    output logic                  osc_en,
    output logic                  scan_en,
    output logic                  dimming_en,
    output logic                  frame_mem_en,
    output logic                  partial_en,
    output logic                  scroll_en,
    output logic                  load_defaults,
    output logic                  diag_busy,
    output logic [7:0]            diag_status
);
    import spn_pkg::*;

    logic [9:0]                 meta_reg;
    logic [9:0]                 sync_reg;
    logic                       wr_prev_reg;
    logic                       cmd_take;
    logic [7:0]                 cmd_byte;
    spn_dev_state_t             state_reg;
    spn_dev_state_t             state_next;
    logic [`SPN_GAP_W-1:0]      wake_cnt_reg;
    logic [`SPN_GAP_W-1:0]      wake_cnt_next;
    logic                       power_reg;
    logic                       dimming_reg;
    logic                       mem_en_reg;
    logic                       partial_reg;
    logic                       scroll_reg;
    logic                       load_reg;
    logic                       busy_reg;
    logic [7:0]                 diag_reg;

    // Pins are asynchronous to aclk; two stages before any logic looks.
    // Only the strobe, the select and the low data lane are kept.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= `SPN_PIN_RST;
            sync_reg <= `SPN_PIN_RST;
        end else begin
            meta_reg <= {link.write_strobe_n, link.data_command_select,
                         link.data[7:0]};
            sync_reg <= meta_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_prev_reg <= 1'b1;
        end else begin
            wr_prev_reg <= sync_reg[9];
        end
    end

    // The host holds the byte stable around the rising strobe, so the
    // synchronised lane is settled when the synchronised edge shows.
    assign cmd_take = sync_reg[9] & ~wr_prev_reg & ~sync_reg[8];
    assign cmd_byte = sync_reg[7:0];

    always_comb begin
        state_next    = state_reg;
        wake_cnt_next = wake_cnt_reg;
        if (wake_cnt_reg != '0) begin
            wake_cnt_next = wake_cnt_reg - 1'b1;
        end
        case (state_reg)
            ST_LOAD: begin
                if (wake_cnt_reg == WAKE_CYCLES[`SPN_GAP_W-1:0]
                        - `SPN_LOAD_CYCLES) begin
                    state_next = ST_DIAG;
                end
            end
            ST_DIAG: begin
                if (wake_cnt_reg == '0) begin
                    state_next = ST_AWAKE;
                end
            end
            default: begin
            end
        endcase
        // Commands are honoured in every state, including the wake window.
        if (cmd_take) begin
            if (cmd_byte == `SPN_OP_SLEEP_ENTER) begin
                if (state_reg != ST_SLEEP) begin
                    state_next    = ST_SLEEP;
                    wake_cnt_next = '0;
                end
            end else if (cmd_byte == `SPN_OP_SLEEP_EXIT) begin
                // A repeat while awake reloads defaults; scanning runs on.
                state_next    = ST_LOAD;
                wake_cnt_next = WAKE_CYCLES[`SPN_GAP_W-1:0] - 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg    <= ST_SLEEP;
            wake_cnt_reg <= '0;
        end else begin
            state_reg    <= state_next;
            wake_cnt_reg <= wake_cnt_next;
        end
    end

    // Converter, oscillator and scan enables follow the sleep state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_reg <= 1'b0;
        end else begin
            power_reg <= (state_next != ST_SLEEP);
        end
    end

    // Dimming drops in the same cycle as the power enables on sleep entry,
    // so no dimming ramp can start on the way down.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dimming_reg <= 1'b0;
        end else begin
            dimming_reg <= (state_next == ST_AWAKE);
        end
    end

    // Host interface and frame memory never stop, asleep or awake.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_en_reg <= 1'b1;
        end else begin
            mem_en_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            partial_reg <= 1'b0;
        end else if (cmd_take && cmd_byte == `SPN_OP_PARTIAL_ON) begin
            if (!partial_reg) begin
                partial_reg <= 1'b1;
            end
        end else if (cmd_take && cmd_byte == `SPN_OP_NORMAL_ON) begin
            if (partial_reg) begin
                partial_reg <= 1'b0;
            end
        end
    end

    // Scroll is started by the scroll logic; a start in the same cycle as
    // a normal-mode command wins so that the event is not lost.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scroll_reg <= 1'b0;
        end else if (scroll_start) begin
            scroll_reg <= 1'b1;
        end else if (cmd_take && cmd_byte == `SPN_OP_NORMAL_ON) begin
            scroll_reg <= 1'b0;
        end
    end

    // Defaults are written only by the load pulse; equal values leave the
    // image untouched because scanning is not interrupted.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            load_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            load_reg <= (state_next == ST_LOAD)
                        && (wake_cnt_next == WAKE_CYCLES[`SPN_GAP_W-1:0]
                            - 1'b1);
            busy_reg <= (state_next == ST_LOAD)
                        || (state_next == ST_DIAG);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            diag_reg <= 8'h00;
        end else begin
            if (state_reg == ST_LOAD && state_next == ST_DIAG) begin
                diag_reg[`SPN_DIAG_LOAD] <= ~diag_reg[`SPN_DIAG_LOAD];
            end
            if (state_reg == ST_DIAG && state_next == ST_AWAKE
                    && panel_ok) begin
                diag_reg[`SPN_DIAG_FUNC] <= ~diag_reg[`SPN_DIAG_FUNC];
            end
        end
    end

    assign dev_state     = state_reg;
    assign dcdc_en       = power_reg;
    assign osc_en        = power_reg;
    assign scan_en       = power_reg;
    assign dimming_en    = dimming_reg;
    assign frame_mem_en  = mem_en_reg;
    assign partial_en    = partial_reg;
    assign scroll_en     = scroll_reg;
    assign load_defaults = load_reg;
    assign diag_busy     = busy_reg;
    assign diag_status   = diag_reg;
endmodule // spn_dev

// ==== hdl/spn_host.sv ====
// Host end: AXI4-Lite command port driving the parallel command bus.
`timescale 1ns/10ps
`include "spn_regs.svh"
module spn_host #(
    parameter int unsigned GAP_CYCLES  = `SPN_GAP_MS * `SPN_CLK_KHZ,
    parameter int unsigned LONG_CYCLES = `SPN_LONG_MS * `SPN_CLK_KHZ
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    spn_link_if.host                    link,
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [`SPN_AXI_AW-1:0] awaddr,
    input  wire logic                   wvalid,
    output logic                        wready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    output logic                        bvalid,
    input  wire logic                   bready,
    output logic [1:0]                  bresp,
    input  wire logic                   arvalid,
    output logic                        arready,
    input  wire logic [`SPN_AXI_AW-1:0] araddr,
    output logic                        rvalid,
    input  wire logic                   rready,
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output spn_pkg::spn_host_state_t    host_state
);
    import spn_pkg::*;

    logic                   aw_got_reg;
    logic [`SPN_AXI_AW-1:0] aw_addr_reg;
    logic                   w_got_reg;
    logic [31:0]            w_data_reg;
    logic                   w_lane0_reg;
    logic                   bvalid_reg;
    logic [1:0]             bresp_reg;
    logic                   rvalid_reg;
    logic [31:0]            rdata_reg;
    logic [1:0]             rresp_reg;
    logic                   wr_fire;
    logic                   cmd_ok;
    logic                   pending_reg;
    logic [7:0]             cmd_reg;
    spn_host_state_t        hst_reg;
    logic [2:0]             ph_cnt_reg;
    logic [`SPN_GAP_W-1:0]  gap_cnt_reg;
    logic [`SPN_LONG_W-1:0] long_cnt_reg;
    logic                   sleep_view_reg;
    logic                   partial_view_reg;
    logic                   wr_n_reg;
    logic                   dc_reg;
    logic                   launch;
    logic                   done;
    logic                   busy;
    logic [31:0]            status;

    assign wr_fire = aw_got_reg & w_got_reg & ~bvalid_reg;
    assign cmd_ok  = wr_fire & (aw_addr_reg == `SPN_ADDR_CMD)
                     & w_lane0_reg & ~pending_reg;
    assign busy    = pending_reg | (gap_cnt_reg != '0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg  <= 1'b0;
            aw_addr_reg <= '0;
            w_got_reg   <= 1'b0;
            w_data_reg  <= 32'h0000_0000;
            w_lane0_reg <= 1'b0;
        end else begin
            if (awvalid && !aw_got_reg) begin
                aw_got_reg  <= 1'b1;
                aw_addr_reg <= awaddr;
            end else if (wr_fire) begin
                aw_got_reg <= 1'b0;
            end
            if (wvalid && !w_got_reg) begin
                w_got_reg   <= 1'b1;
                w_data_reg  <= wdata;
                w_lane0_reg <= wstrb[0];
            end else if (wr_fire) begin
                w_got_reg <= 1'b0;
            end
        end
    end

    // A command write while one is still queued is answered with an error.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `SPN_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= cmd_ok ? `SPN_RESP_OKAY : `SPN_RESP_SLVERR;
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign status = {28'h0, 1'b0, 1'b0, 1'b0, 1'b0}
                    | ({31'h0, busy} << `SPN_ST_BUSY)
                    | ({31'h0, sleep_view_reg} << `SPN_ST_SLEEP)
                    | ({31'h0, partial_view_reg} << `SPN_ST_PARTIAL)
                    | ({31'h0, long_cnt_reg != '0} << `SPN_ST_LONG);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= `SPN_RESP_OKAY;
        end else if (arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= `SPN_RESP_OKAY;
            if (araddr == `SPN_ADDR_CMD) begin
                rdata_reg <= {24'h00_0000, cmd_reg};
            end else if (araddr == `SPN_ADDR_STATUS) begin
                rdata_reg <= status;
            end else begin
                rdata_reg <= 32'h0000_0000;
                rresp_reg <= `SPN_RESP_SLVERR;
            end
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Sleep commands also wait out the long interval after a sleep change.
    assign launch = (hst_reg == H_IDLE) && pending_reg
                    && (gap_cnt_reg == '0)
                    && !(spn_is_sleep_op(cmd_reg)
                         && long_cnt_reg != '0);
    assign done   = (hst_reg == H_HOLD) && (ph_cnt_reg == 3'h0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending_reg <= 1'b0;
            cmd_reg     <= 8'h00;
        end else if (cmd_ok) begin
            pending_reg <= 1'b1;
            cmd_reg     <= w_data_reg[7:0];
        end else if (done) begin
            pending_reg <= 1'b0;
        end
    end

    // Setup, low and hold phases keep the byte steady across the device's
    // two-stage pin synchroniser.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hst_reg    <= H_IDLE;
            ph_cnt_reg <= 3'h0;
            wr_n_reg   <= 1'b1;
            dc_reg     <= 1'b1;
        end else begin
            case (hst_reg)
                H_IDLE: begin
                    if (launch) begin
                        hst_reg    <= H_SETUP;
                        ph_cnt_reg <= `SPN_SETUP_CYCLES - 3'h1;
                        dc_reg     <= 1'b0;
                    end
                end
                H_SETUP: begin
                    if (ph_cnt_reg == 3'h0) begin
                        hst_reg    <= H_LOW;
                        ph_cnt_reg <= `SPN_LOW_CYCLES - 3'h1;
                        wr_n_reg   <= 1'b0;
                    end else begin
                        ph_cnt_reg <= ph_cnt_reg - 3'h1;
                    end
                end
                H_LOW: begin
                    if (ph_cnt_reg == 3'h0) begin
                        hst_reg    <= H_HOLD;
                        ph_cnt_reg <= `SPN_HOLD_CYCLES - 3'h1;
                        wr_n_reg   <= 1'b1;
                    end else begin
                        ph_cnt_reg <= ph_cnt_reg - 3'h1;
                    end
                end
                default: begin
                    if (ph_cnt_reg == 3'h0) begin
                        hst_reg <= H_IDLE;
                        dc_reg  <= 1'b1;
                    end else begin
                        ph_cnt_reg <= ph_cnt_reg - 3'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gap_cnt_reg  <= '0;
            long_cnt_reg <= '0;
        end else begin
            if (done && spn_is_sleep_op(cmd_reg)) begin
                gap_cnt_reg <= GAP_CYCLES[`SPN_GAP_W-1:0];
            end else if (gap_cnt_reg != '0) begin
                gap_cnt_reg <= gap_cnt_reg - 1'b1;
            end
            if (done && ((cmd_reg == `SPN_OP_SLEEP_EXIT && sleep_view_reg)
                    || (cmd_reg == `SPN_OP_SLEEP_ENTER
                        && !sleep_view_reg))) begin
                long_cnt_reg <= LONG_CYCLES[`SPN_LONG_W-1:0];
            end else if (long_cnt_reg != '0) begin
                long_cnt_reg <= long_cnt_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sleep_view_reg   <= 1'b1;
            partial_view_reg <= 1'b0;
        end else if (done) begin
            if (cmd_reg == `SPN_OP_SLEEP_ENTER) begin
                sleep_view_reg <= 1'b1;
            end else if (cmd_reg == `SPN_OP_SLEEP_EXIT) begin
                sleep_view_reg <= 1'b0;
            end else if (cmd_reg == `SPN_OP_PARTIAL_ON) begin
                partial_view_reg <= 1'b1;
            end else if (cmd_reg == `SPN_OP_NORMAL_ON) begin
                partial_view_reg <= 1'b0;
            end
        end
    end

    assign link.write_strobe_n      = wr_n_reg;
    assign link.read_strobe_n       = aresetn | 1'b1;
    assign link.data_command_select = dc_reg;
    assign link.data                = {8'h00, cmd_reg};
    assign awready    = ~aw_got_reg;
    assign wready     = ~w_got_reg;
    assign bvalid     = bvalid_reg;
    assign bresp      = bresp_reg;
    assign arready    = ~rvalid_reg;
    assign rvalid     = rvalid_reg;
    assign rdata      = rdata_reg;
    assign rresp      = rresp_reg;
    assign host_state = hst_reg;
endmodule // spn_host

// ==== verification/spn_link_props.sv ====
// Concurrent checks on the command link and the device mode outputs.
`timescale 1ns/10ps
module spn_link_props (
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              write_strobe_n,
    input wire logic              data_command_select,
    input wire logic [15:0]       data,
    input spn_pkg::spn_dev_state_t dev_state,
    input wire logic              dcdc_en,
    input wire logic              osc_en,
    input wire logic              scan_en,
    input wire logic              dimming_en,
    input wire logic              frame_mem_en,
    input wire logic              partial_en,
    input wire logic              diag_busy
);
    import spn_pkg::*;
    // The wake window is bounded by the shortened parameter used on the bench.
    localparam int WIN = 60;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence strobe_low_s;
        !write_strobe_n [*4] ##1 write_strobe_n;
    endsequence
    sequence sel_hold_s;
        !data_command_select [*4] ##1 data_command_select;
    endsequence
    strobe_low_a: assert property ($fell(write_strobe_n) |-> strobe_low_s)
        else $error("write strobe low time wrong");
    select_hold_a: assert property ($rose(write_strobe_n) |-> sel_hold_s)
        else $error("select hold after strobe wrong");
    command_select_a: assert property ($fell(write_strobe_n) |->
        !data_command_select && $stable(data))
        else $error("strobe without command select");
    upper_lane_a: assert property (!data_command_select |-> data[15:8] == 8'h00)
        else $error("upper data lane not zero");
    frame_mem_a: assert property (frame_mem_en)
        else $error("frame memory disabled");
    supply_enables_a: assert property ((dcdc_en == (dev_state != ST_SLEEP))
        && osc_en == dcdc_en && scan_en == dcdc_en)
        else $error("supply enables disagree with state");
    dimming_awake_a: assert property (dimming_en |-> dev_state == ST_AWAKE)
        else $error("dimming outside awake state");
    wake_path_a: assert property (dev_state == ST_SLEEP ##1
        dev_state != ST_SLEEP |-> dev_state == ST_LOAD)
        else $error("sleep left without load phase");
    diag_window_a: assert property ($rose(diag_busy) |-> ##[1:WIN] !diag_busy)
        else $error("wake window too long");
    sleep_gap_a: assert property ($rose(write_strobe_n) &&
        (data[7:0] == 8'h10 || data[7:0] == 8'h11) |-> write_strobe_n [*8])
        else $error("command sent too soon after sleep change");
    reset_state_a: assert property ($rose(aresetn) |->
        dev_state == ST_SLEEP && !partial_en)
        else $error("reset state wrong");
endmodule // spn_link_props

// ==== verification/tb.sv ====
// Bench driving commands over AXI4-Lite through host and device ends.
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module tb;
    import spn_pkg::*;
    logic        aclk, aresetn, scroll_start, panel_ok;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, st;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic        dcdc_en, osc_en, scan_en, dimming_en, frame_mem_en;
    logic        partial_en, scroll_en, load_defaults, diag_busy;
    logic [7:0]  diag_status;
    int          num_errors, n_tests, cyc, loads;
    spn_dev_state_t  dev_state;
    spn_host_state_t host_state;
    spn_link_if link();
    spn_host #(.GAP_CYCLES(20), .LONG_CYCLES(60)) i_spn_host (.aclk, .aresetn,
        .link(link), .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
        .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .rvalid, .rready, .rdata, .rresp, .host_state);
    spn_dev #(.WAKE_CYCLES(40)) i_spn_dev (.aclk, .aresetn, .link(link),
        .scroll_start, .panel_ok, .dev_state, .dcdc_en, .osc_en, .scan_en,
        .dimming_en, .frame_mem_en, .partial_en, .scroll_en, .load_defaults,
        .diag_busy, .diag_status);
    spn_link_props i_spn_link_props (.aclk, .aresetn,
        .write_strobe_n(link.write_strobe_n),
        .data_command_select(link.data_command_select), .data(link.data),
        .dev_state, .dcdc_en, .osc_en, .scan_en, .dimming_en, .frame_mem_en,
        .partial_en, .diag_busy);
    task automatic print_verdict();
        if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= a; wdata <= d; wstrb <= s;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d,
                      output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata; rs = rresp;
        rready <= 1'b0;
    endtask
    // Sends one command and waits until the host reports it fully spent.
    task automatic cmd(input logic [7:0] op);
        wr(4'h0, {24'h0, op}, 4'h1, r);
        `CHK(r, 2'h0)
        do rd(4'h4, st, r); while (st[0] !== 1'b0);
    endtask
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    initial begin
        cyc = 0;
        loads = 0;
        forever begin
            @(posedge aclk);
            cyc++;
            // The load pulse lasts one cycle, so it is counted on every edge.
            if (load_defaults === 1'b1) loads++;
            if (cyc > 20000) begin
                num_errors++;
                print_verdict();
            end
        end
    end
    initial begin
        aresetn = 1'b0; scroll_start = 1'b0; panel_ok = 1'b1;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
        rready = 1'b0; awaddr = 4'h0; araddr = 4'h0; wstrb = 4'h0;
        wdata = 32'h0; num_errors = 0; n_tests = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h4, st, r);
        `CHK(st, 32'h00000002)
        `CHK({dev_state, partial_en}, {ST_SLEEP, 1'b0})
        cmd(8'h10);
        `CHK({dev_state, dcdc_en}, {ST_SLEEP, 1'b0})
        cmd(8'h12);
        `CHK(partial_en, 1'b1)
        cmd(8'h12);
        `CHK({partial_en, dev_state}, {1'b1, ST_SLEEP})
        cmd(8'h11);
        while (dev_state !== ST_AWAKE) @(posedge aclk);
        `CHK({dcdc_en, osc_en, scan_en, dimming_en}, 4'hf)
        `CHK(diag_status, 8'hc0)
        `CHK(loads, 1)
        @(posedge aclk);
        scroll_start <= 1'b1;
        @(posedge aclk);
        scroll_start <= 1'b0;
        cmd(8'h13);
        `CHK({partial_en, scroll_en}, 2'b00)
        cmd(8'h13);
        `CHK({partial_en, dev_state}, {1'b0, ST_AWAKE})
        cmd(8'h10);
        `CHK({dev_state, dcdc_en, dimming_en}, {ST_SLEEP, 2'b00})
        rd(4'h4, st, r);
        `CHK(st, 32'h0000000a)
        `CHK({host_state, link.read_strobe_n}, {H_IDLE, 1'b1})
        rd(4'h0, st, r);
        `CHK(st[7:0], 8'h10)
        wr(4'h8, 32'h11, 4'h1, r);
        `CHK(r, 2'h2)
        wr(4'h4, 32'h11, 4'h1, r);
        `CHK(r, 2'h2)
        wr(4'h0, 32'h11, 4'h2, r);
        `CHK(r, 2'h2)
        rd(4'hc, st, r);
        `CHK({r, st}, {2'h2, 32'h0})
        `CHK(dev_state, ST_SLEEP)
        print_verdict();
    end
endmodule // tb
